// ===== eepc_pkg.sv
// Package with constants, encodings and the state carrier of the serial EEPROM command port.
// Functional notes
// [RL1] First one after select rise is start.
// [RL2] Zeros before the start bit are ignored.
// [RL3] Address and data travel MSB first.
// [RL4] Opcode 10 read, 01 write, 11 erase.
// [RL5] Opcode 00: top address bits pick operation.
// [RL6] Address field is 6, 8 or 10 bits.
// [RL7] Dummy zero at last address bit, then word.
// [RL8] Continued clocking reads following addresses in sequence.
// [RL9] Write programs at select fall after D0.
// [RL10] Program cycle at most 5 ms, busy refuses.
// [RL11] Write-all programs every word in one go.
// [RL12] Write and write-all erase cells before programming.
// [RL13] Write-enable latch cleared at power-up.
// [RL14] Enable persists; reads ignore the latch.
// [RL15] After disable, program and erase commands ignored.
// [RL16] Host clocks the don't-care bits anyway.
// [RL17] Host should disable writes after programming.
// [RL18] Erase sets addressed word to all ones.
// [RL19] Chip erase sets all words, reports status.
// [RL20] Select low abandons a read.
// [RL21] Write cancellable only before the commit clock.
// [RL22] Clocking past commit cannot cancel a write.
// [RL23] Sample input and drive output on rises.
// [RL24] Output shows busy low, ready high.
// [RL25] Host drops select after every command.
// [RL26] Select low clears counter and decode state.
package eepc_pkg;

  // Word width of the array and the value an erased word holds.
  localparam int WORD_W = 16;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // Widest address field that the carrier has room for.
  localparam int ADDR_MAX = 10;
  localparam int ADDR_DEF = 6;

  // Two-bit opcodes that follow the start bit.
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;

  // Extended group selectors held in the two top address bits.
  localparam logic [1:0] EXT_DIS = 2'h0;
  localparam logic [1:0] EXT_PROG_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_EN = 2'h3;

  // Program cycle time in nanoseconds and the system clock period.
  localparam longint PROG_TIME_NS = 5000000;
  localparam longint CLK_PERIOD_NS = 10;
  // Longest time, so the count rounds down.
  localparam int PROG_CYCLES_DEF = int'(PROG_TIME_NS / CLK_PERIOD_NS);
  localparam int TMR_W = 24;

  // Command sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_READ,
    ST_DATA,
    ST_ARMED,
    ST_SKIP
  } eepc_state_t;

  // Pending program operation.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_WRITE,
    OP_PROG_ALL,
    OP_ERASE,
    OP_ERASE_ALL
  } eepc_op_t;

  // Complete register state of the command port, apart from the word array.
  typedef struct packed {
    eepc_state_t st;
    eepc_op_t op;
    logic [4:0] cnt;
    logic [ADDR_MAX+1:0] hdr;
    logic [ADDR_MAX-1:0] addr;
    logic [15:0] data;
    logic [15:0] rd_word;
    logic [3:0] rd_bit;
    logic wen;
    logic busy;
    logic status;
    logic [TMR_W-1:0] timer;
    logic rd_drive;
    logic dout;
    logic so;
    logic so_oe_n;
  } eepc_regs_t;

endpackage

// ===== eepc_pin_sync.sv
// Two-flop synchroniser with edge detection for asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module eepc_pin_sync
#(
  parameter int W = 1
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // First stage only feeds the second stage, never any logic.
  logic [W-1:0] meta_q;
  // Second stage is the safe level; third remembers it for edge finding.
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Shift the pins through three flops on every clock.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are one system cycle long and come from the settled stages.
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule
`default_nettype wire

// ===== eepc_port.sv
// Command decoder, sequencer and word array of the serial EEPROM command port.
`timescale 1ns/1ps
`default_nettype none
module eepc_port
  import eepc_pkg::*;
#(
  parameter int ADDR_W = ADDR_DEF,
  parameter int DEPTH = 64,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic select_in,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic busy
);

  // Index width of the word array; the top field bit may be unused.
  localparam int MEM_AW = $clog2(DEPTH);
  // Clock rise, counted after the start bit, that ends the header.
  localparam logic [4:0] HDR_BITS = 5'(2 + ADDR_W);
  // Clock rise, counted after the start bit, that takes the last data bit.
  localparam logic [4:0] DATA_END = 5'(2 + ADDR_W + WORD_W);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(PROG_CYCLES - 1);
  localparam logic [3:0] BIT_MSB = 4'(WORD_W - 1);

  // Synchronised pins: index 0 select, 1 serial clock, 2 serial data.
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic cs_lvl;
  logic cs_fall;
  logic link_clk_rise;
  logic si;

  // Register set and its next value.
  eepc_regs_t s_q;
  eepc_regs_t s_d;

  // The word array itself.
  logic [15:0] mem [DEPTH];
  // Array write happens on the last cycle of the program timer.
  logic prog_done;

  // All three pins come from the host, outside the system clock domain.
  eepc_pin_sync #(
    .W(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({serial_in, serial_clock_in, select_in}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_lvl = pin_lvl[0];
  assign cs_fall = pin_fall[0];
  // Only rises while selected count; the input is taken at that rise.
  assign link_clk_rise = pin_rise[1] & pin_lvl[0]; // RL23
  assign si = pin_lvl[2];
  assign prog_done = s_q.busy && (s_q.timer == '0);

  // Next-state logic of the whole sequencer.
  always_comb
  begin
    logic [ADDR_MAX+1:0] hdr_n;
    logic [1:0] opc;
    logic [1:0] ext;
    logic [ADDR_MAX-1:0] adr;
    logic [4:0] cnt_n;
    logic [MEM_AW-1:0] nidx;
    hdr_n = '0;
    opc = '0;
    ext = '0;
    adr = '0;
    cnt_n = '0;
    nidx = '0;
    s_d = s_q;

    // Program timer runs whatever the pins do.
    if (s_q.busy)
    begin
      if (s_q.timer == '0)
      begin
        s_d.busy = 1'b0;
        s_d.op = OP_NONE;
      end
      else
      begin
        s_d.timer = s_q.timer - 1'b1;
      end
    end

    if (!cs_lvl)
    begin
      // Deselected: drop any partial frame and any read in flight.
      s_d.st = ST_IDLE; // RL26 RL20
      s_d.cnt = '0; // RL26
      s_d.rd_drive = 1'b0;
      if (cs_fall && (s_q.st == ST_ARMED))
      begin
        // Select fall after the final command clock starts programming.
        s_d.busy = 1'b1; // RL9 RL18 RL19
        s_d.timer = TMR_LOAD; // RL10
        s_d.status = 1'b1; // RL24
      end
      else if (s_q.st != ST_ARMED && !s_q.busy)
      begin
        // A frame that never reached its commit point is discarded.
        s_d.op = OP_NONE; // RL21
      end
    end
    else if (link_clk_rise)
    begin
      cnt_n = s_q.cnt + 5'h1;
      unique case (s_q.st)
        ST_IDLE:
        begin
          // Leading zeros are skipped; busy refuses any new command.
          if (si && !s_q.busy) // RL1 RL2 RL10
          begin
            s_d.st = ST_HDR;
            s_d.cnt = '0;
            s_d.hdr = '0;
            s_d.status = 1'b0; // RL24
          end
        end
        ST_HDR:
        begin
          // Opcode and address shift in MSB first.
          hdr_n = {s_q.hdr[ADDR_MAX:0], si}; // RL3
          s_d.hdr = hdr_n;
          s_d.cnt = cnt_n;
          if (cnt_n == HDR_BITS) // RL6
          begin
            opc = hdr_n[ADDR_W+1 -: 2]; // RL4
            ext = hdr_n[ADDR_W-1 -: 2]; // RL5
            adr = ADDR_MAX'(hdr_n[ADDR_W-1:0]);
            s_d.addr = adr;
            s_d.st = ST_SKIP;
            unique case (opc)
              OPC_READ:
              begin
                // Dummy zero at the rise that takes the last address bit.
                s_d.st = ST_READ; // RL7 RL14
                s_d.dout = 1'b0; // RL7
                s_d.rd_drive = 1'b1;
                s_d.rd_word = mem[MEM_AW'(adr)];
                s_d.rd_bit = BIT_MSB;
              end
              OPC_WRITE:
              begin
                // Ignored while the latch is clear.
                if (s_q.wen) // RL15
                begin
                  s_d.st = ST_DATA;
                  s_d.op = OP_WRITE;
                end
              end
              OPC_ERASE:
              begin
                if (s_q.wen) // RL15
                begin
                  s_d.st = ST_ARMED; // RL18
                  s_d.op = OP_ERASE;
                end
              end
              OPC_EXT:
              begin
                unique case (ext)
                  EXT_EN: s_d.wen = 1'b1; // RL14
                  EXT_DIS: s_d.wen = 1'b0; // RL15
                  EXT_PROG_ALL:
                  begin
                    if (s_q.wen) // RL15
                    begin
                      s_d.st = ST_DATA;
                      s_d.op = OP_PROG_ALL; // RL11
                    end
                  end
                  EXT_ERASE_ALL:
                  begin
                    if (s_q.wen) // RL15
                    begin
                      s_d.st = ST_ARMED; // RL19
                      s_d.op = OP_ERASE_ALL;
                    end
                  end
                endcase
              end
            endcase
          end
        end
        ST_READ:
        begin
          // Each rise puts out the next bit of the word, MSB first.
          s_d.dout = s_q.rd_word[s_q.rd_bit]; // RL7 RL3
          if (s_q.rd_bit == '0)
          begin
            // Continued clocking moves on to the following address.
            s_d.addr = s_q.addr + 1'b1; // RL8
            nidx = MEM_AW'(s_q.addr) + 1'b1;
            s_d.rd_word = mem[nidx]; // RL8
            s_d.rd_bit = BIT_MSB;
          end
          else
          begin
            s_d.rd_bit = s_q.rd_bit - 1'b1;
          end
        end
        ST_DATA:
        begin
          s_d.data = {s_q.data[14:0], si}; // RL3
          s_d.cnt = cnt_n;
          // The rise that takes D0 is the commit point.
          if (cnt_n == DATA_END) // RL21
          begin
            s_d.st = ST_ARMED; // RL9
          end
        end
        ST_ARMED:
        begin
          // Extra clocks past commit change nothing.
          s_d.st = ST_ARMED; // RL22
        end
        ST_SKIP:
        begin
          // Don't-care bits and ignored commands soak up clocks here.
          s_d.st = ST_SKIP;
        end
      endcase
    end

    // Output pin: read data, else status, else released.
    if (cs_lvl && s_d.rd_drive)
    begin
      s_d.so = s_d.dout;
      s_d.so_oe_n = 1'b0;
    end
    else if (cs_lvl && s_d.status)
    begin
      s_d.so = ~s_d.busy; // RL24
      s_d.so_oe_n = 1'b0;
    end
    else
    begin
      s_d.so = 1'b0;
      s_d.so_oe_n = 1'b1; // RL24
    end
  end

  // State register; the write-enable latch starts cleared.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '{st: ST_IDLE, op: OP_NONE, so_oe_n: 1'b1, default: '0}; // RL13
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Array update at the end of the program cycle. Erase-before-write is
  // folded into the overwrite, so no cell ever sees a stale mix of bits.
  always_ff @(posedge clk_sys)
  begin
    if (prog_done)
    begin
      unique case (s_q.op)
        OP_WRITE: mem[MEM_AW'(s_q.addr)] <= s_q.data; // RL9 RL12
        OP_ERASE: mem[MEM_AW'(s_q.addr)] <= ERASED_WORD; // RL18
        OP_PROG_ALL:
        begin
          for (int i = 0; i < DEPTH; i++)
          begin
            mem[i] <= s_q.data; // RL11 RL12
          end
        end
        OP_ERASE_ALL:
        begin
          for (int i = 0; i < DEPTH; i++)
          begin
            mem[i] <= ERASED_WORD; // RL19
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // Pin outputs come straight from the state register.
  assign serial_out = s_q.so;
  assign serial_out_oe_n = s_q.so_oe_n;
  assign busy = s_q.busy;

endmodule
`default_nettype wire

// ===== eepc_port_sva.sv
// Pin-level checks of the serial EEPROM command port.
`timescale 1ns/1ps
`default_nettype none
module eepc_port_sva
#(
  parameter int PROG_CYCLES = 50
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic select_in,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic busy
);
  // Busy cycles so far; a reset clears it, so a busy drop caused by reset is ignored.
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  always_comb cnt_d = busy ? cnt_q + 24'h1 : 24'h0;
  // Counter register.
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      cnt_q <= 24'h0;
    else
      cnt_q <= cnt_d;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_desel; !select_in [*6]; endsequence
  sequence s_done; $fell(busy) && cnt_q != 24'h0; endsequence
  sequence s_busy_sel; (select_in && busy) [*6]; endsequence
  sequence s_quiet; (select_in && !serial_clock_in && !busy) [*6]; endsequence
  property p_release; s_desel |-> serial_out_oe_n; endproperty
  property p_busy_start; $rose(busy) |-> !$past(select_in, 2); endproperty
  property p_busy_len; s_done |-> cnt_q == PROG_CYCLES; endproperty
  property p_busy_max; busy |-> cnt_q < PROG_CYCLES; endproperty
  property p_busy_status; s_busy_sel |-> !serial_out_oe_n && !serial_out; endproperty
  property p_ready; s_done ##0 select_in |-> ##[0:4] (serial_out && !serial_out_oe_n); endproperty
  property p_quiet; s_quiet |=> $stable(serial_out); endproperty
  property p_drive_sel; $fell(serial_out_oe_n) |-> select_in && $past(select_in, 2); endproperty
  a_release: assert property (p_release)
    else $error("output still driven after deselect");
  a_busy_start: assert property (p_busy_start)
    else $error("program began while selected");
  a_busy_len: assert property (p_busy_len)
    else $error("program cycle length wrong");
  a_busy_max: assert property (p_busy_max)
    else $error("program cycle too long");
  a_busy_status: assert property (p_busy_status)
    else $error("busy status not shown low");
  a_ready: assert property (p_ready)
    else $error("ready status not shown high");
  a_quiet: assert property (p_quiet)
    else $error("output moved without a clock rise");
  a_drive_sel: assert property (p_drive_sel)
    else $error("output driven while not selected");
endmodule
bind eepc_port eepc_port_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.clk_sys(clk_sys),
  .rst_n(rst_n), .select_in(select_in), .serial_clock_in(serial_clock_in),
  .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
  .busy(busy));
`default_nettype wire

// ===== eepc_host.sv
// Behavioural host that frames commands on the select, clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module eepc_host
(
  input wire logic clk_sys,
  input wire logic do_pin,
  output logic select_in,
  output logic serial_clock_in,
  output logic serial_in,
  output logic [15:0] rx_word,
  output logic rx_stb
);
  // Read bits gathered just before each clock rise, when the output has settled.
  logic [15:0] sh;
  initial
  begin
    select_in = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
    rx_word = 16'h0000;
    rx_stb = 1'b0;
    sh = 16'h0000;
  end
  // The word strobe lasts one cycle; words come 128 cycles apart at least.
  always @(posedge clk_sys)
    if (rx_stb)
      rx_stb <= 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One link clock of 80 ns: low half with data set up, then high half.
  task automatic bit_cyc(input logic d, input bit rd, input int j);
    serial_clock_in <= 1'b0;
    serial_in <= d;
    tick(4);
    if (rd)
    begin
      if (j == 0)
        sh = 16'h0000;
      sh = {sh[14:0], do_pin};
      if (j % 16 == 0)
      begin
        rx_word <= sh;
        rx_stb <= 1'b1;
      end
    end
    serial_clock_in <= 1'b1;
    tick(4);
  endtask
  // Deselect; the data line then wanders, so nothing may lean on its old value.
  task automatic drop();
    select_in <= 1'b0;
    serial_clock_in <= 1'b0;
    serial_in <= ~serial_in;
    tick(10);
  endtask
  // Sends n bits from the top of b, then nx further clocks with the line low.
  task automatic frame(input logic [31:0] b, input int n, input int nx, input bit rd);
    select_in <= 1'b1;
    serial_clock_in <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++)
      bit_cyc(b[31-i], 1'b0, 1);
    for (int j = 0; j < nx; j++)
      bit_cyc(1'b0, rd, j);
    drop();
  endtask
  // Polls status with the clock still, and issues nothing until ready or 400 cycles have passed.
  task automatic wait_ready();
    select_in <= 1'b1;
    serial_in <= 1'b0;
    tick(6);
    for (int i = 0; i < 400 && do_pin !== 1'b1; i++)
      tick(1);
    drop();
  endtask
endmodule
`default_nettype wire

// ===== eepc_port_tb_top.sv
// Self-checking testbench of the serial EEPROM command port.
`timescale 1ns/1ps
`default_nettype none
module eepc_port_tb_top;
  import eepc_pkg::*;
  `define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
  localparam int PC = 50;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic select_in, serial_clock_in, serial_in, serial_out, serial_out_oe_n, busy;
  logic do_pin, rx_stb;
  logic [15:0] rx_word, e;
  logic [15:0] exp_q[$];
  logic [15:0] d[3];
  logic [31:0] seed = 32'hBABEA444;
  int fails = 0;
  int samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  // Pulled up when released, so a floating line reads as one, the same as ready status.
  assign do_pin = serial_out_oe_n ? 1'b1 : serial_out;
  eepc_port #(.ADDR_W(6), .DEPTH(64), .PROG_CYCLES(PC)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .select_in(select_in), .serial_clock_in(serial_clock_in),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .busy(busy));
  eepc_host host (.clk_sys(clk_sys), .do_pin(do_pin), .select_in(select_in),
    .serial_clock_in(serial_clock_in), .serial_in(serial_in), .rx_word(rx_word),
    .rx_stb(rx_stb));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Start bit, opcode, address and data, left aligned.
  function automatic logic [31:0] cmd(logic [1:0] op, logic [5:0] a, logic [15:0] w);
    return {1'b1, op, a, w, 7'h00};
  endfunction
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Sends a frame and checks whether a program cycle was started by it.
  task automatic go(logic [31:0] b, int n, int nx, logic eb);
    host.frame(b, n, nx, 1'b0);
    `CHK(busy, eb)
    if (eb)
    begin
      host.wait_ready();
      `CHK(busy, 1'b0)
    end
  endtask
  task automatic rd(logic [5:0] a, int nw);
    host.frame(cmd(OPC_READ, a, 16'h0000), 9, 16 * nw + 1, 1'b1);
  endtask
  // Each word seen at the host is compared with the oldest expectation.
  always @(posedge clk_sys)
    if (rx_stb === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
      `CHK(rx_word, e)
    end
  // A hang counts as a failure.
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 3; i++)
      d[i] = 16'(rnd());
    go(cmd(OPC_WRITE, 6'h03, d[0]), 25, 0, 1'b0);
    go(cmd(OPC_EXT, {EXT_EN, 4'h5}, 16'h0000) >> 3, 12, 0, 1'b0);
    go(cmd(OPC_EXT, {EXT_ERASE_ALL, 4'hA}, 16'h0000), 9, 0, 1'b1);
    go(cmd(OPC_WRITE, 6'h03, d[0]), 25, 0, 1'b1);
    go(cmd(OPC_WRITE, 6'h04, d[1]), 24, 0, 1'b0);
    go(cmd(OPC_WRITE, 6'h04, d[1]), 25, 5, 1'b1);
    exp_q = {exp_q, 16'h0000, d[0], d[1]};
    rd(6'h03, 2);
    go(cmd(OPC_ERASE, 6'h03, 16'h0000), 9, 0, 1'b1);
    exp_q = {exp_q, 16'h0000, ERASED_WORD};
    rd(6'h03, 1);
    go(cmd(OPC_EXT, {EXT_PROG_ALL, 4'h3}, d[2]), 25, 0, 1'b1);
    exp_q = {exp_q, 16'h0000, d[2], d[2]};
    rd(6'h3F, 2);
    // A disable sent while an erase runs must be refused, so writes stay enabled.
    host.frame(cmd(OPC_ERASE, 6'h05, 16'h0000), 9, 0, 1'b0);
    `CHK(busy, 1'b1)
    host.frame(cmd(OPC_EXT, {EXT_DIS, 4'h0}, 16'h0000), 9, 0, 1'b0);
    go(cmd(OPC_WRITE, 6'h05, d[1]), 25, 0, 1'b1);
    go(cmd(OPC_EXT, {EXT_DIS, 4'hC}, 16'h0000), 9, 0, 1'b0);
    go(cmd(OPC_WRITE, 6'h04, d[0]), 25, 0, 1'b0);
    go(cmd(OPC_ERASE, 6'h04, 16'h0000), 9, 0, 1'b0);
    go(cmd(OPC_EXT, {EXT_ERASE_ALL, 4'h0}, 16'h0000), 9, 0, 1'b0);
    go(cmd(OPC_EXT, {EXT_PROG_ALL, 4'hF}, d[0]), 25, 0, 1'b0);
    host.frame(cmd(OPC_READ, 6'h02, 16'h0000), 9, 9, 1'b0);
    `CHK(serial_out_oe_n, 1'b1)
    exp_q = {exp_q, 16'h0000, d[2]};
    rd(6'h04, 1);
    `CHK(exp_q.size(), 0)
    stop_test();
  end
endmodule
`default_nettype wire
